// ---- iscu_top.v ----
// status groups, error queue and command gating of the power source
// assumes an apb master on clk; status pins come from other clock domains
//
// What this block does
// - falling filter sets event on 1-to-0
// - rising filter sets event on 0-to-1
// - both filters zero block all changes
// - warning registers limited to 0..29947
// - gain limited 220.0 low, 440.0 high
// - clamp samples to -16384..16383
// - binary upload only over usb
// - slot clear restores sine, square, triangle
// - slot clear refused with output on
// - error fifo of twenty, oldest first
// - overflow code -350 in twentieth place
// - power-on output unless fault-lock restart
// - time unit 0 seconds, 1 milliseconds
// - warning release needs all causes gone
// - sequence takes exactly five actions
// - no sequence in external modes, error 3
// - no sequence with output off, error 2
// - clear wipes events, status and errors
// - event status read returns and clears
// - opc sets bit 0 when idle
// - memories 1..30, recall/reset blocked output-on
// - event summary from enabled event bits
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "iscu_defines.vh"

module iscu_top #(
	parameter WARN_W = 15,
	parameter ERRQ_DEPTH = 20,
	parameter PON_DEFAULT = 1'b0
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire pslverr,
	output reg [31:0] prdata,
	// device status pins
	input wire [WARN_W-1:0] warn_cond_pin,
	input wire op_summary_pin,
	input wire external_input_mode,
	input wire added_input_mode,
	input wire external_sync_mode,
	input wire high_range_pin,
	input wire link_usb_pin,
	input wire startup_done_pin,
	input wire fault_restart_pin,
	input wire warn_active_pin,
	input wire warn_clearable_pin,
	input wire ops_busy_pin,
	// device controls
	output reg output_on_q,
	output reg step_unit_ms_q,
	output reg [12:0] gain_q,
	output reg seq_go_q,
	output reg [2:0] seq_action_q,
	output reg slot_clear_q,
	output reg [3:0] slot_q,
	output reg [1:0] slot_shape_q,
	output reg recall_q,
	output reg save_q,
	output reg [4:0] mem_q,
	output reg factory_reset_q,
	output reg warn_release_q,
	// waveform sample write
	output reg wave_we_q,
	output reg [11:0] wave_addr_q,
	output reg [15:0] wave_data_q
);

	// ****************************************
	// helpers
	// ****************************************
	function [15:0] clamp_sample;
		input [15:0] w;
		begin
			if ($signed(w) < $signed(`ISCU_SAMP_MIN))
				clamp_sample = `ISCU_SAMP_MIN;
			else if ($signed(w) > $signed(`ISCU_SAMP_MAX))
				clamp_sample = `ISCU_SAMP_MAX;
			else
				clamp_sample = w;
		end
	endfunction

	function in_range;
		input [7:0] v;
		input [7:0] lo;
		input [7:0] hi;
		begin
			in_range = (v >= lo) && (v <= hi);
		end
	endfunction

	// ****************************************
	// input synchronisers
	// ****************************************
	localparam SYN_W = WARN_W + 12;
	wire [SYN_W-1:0] pins = {warn_cond_pin, op_summary_pin, external_input_mode, added_input_mode,
		external_sync_mode, high_range_pin, link_usb_pin, startup_done_pin, fault_restart_pin,
		warn_active_pin, warn_clearable_pin, ops_busy_pin, 1'b0};
	reg [SYN_W-1:0] meta_q;
	reg [SYN_W-1:0] sync_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= {SYN_W{1'b0}};
			sync_q <= {SYN_W{1'b0}};
		end else begin
			meta_q <= pins;
			sync_q <= meta_q;
		end
	end
	wire [WARN_W-1:0] wcond = sync_q[SYN_W-1:12];
	wire op_sum = sync_q[11];
	wire ext_mode = sync_q[10] | sync_q[9] | sync_q[8];
	wire hi_range = sync_q[7];
	wire link_usb = sync_q[6];
	wire startup_done = sync_q[5];
	wire fault_restart = sync_q[4];
	wire warn_active = sync_q[3];
	wire warn_clearable = sync_q[2];
	wire ops_busy = sync_q[1];

	// ****************************************
	// apb decode
	// ****************************************
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire wr = access & pwrite;
	wire rd = access & ~pwrite;
	reg mapped;
	always @* begin
		case (paddr)
		`ISCU_A_WCOND, `ISCU_A_WEVENT, `ISCU_A_WENABLE, `ISCU_A_WRISE, `ISCU_A_WFALL,
		`ISCU_A_ESR, `ISCU_A_ESE, `ISCU_A_STB, `ISCU_A_ERROR, `ISCU_A_CMD, `ISCU_A_GAIN,
		`ISCU_A_WAVE, `ISCU_A_STATUS, `ISCU_A_OPCQ: mapped = 1'b1;
		default: mapped = 1'b0;
		endcase
	end
	// zero wait states; data is captured in the setup cycle
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;

	// ****************************************
	// state
	// ****************************************
	reg [WARN_W-1:0] wprev_q;
	reg [WARN_W-1:0] wevent_q;
	reg [WARN_W-1:0] wenable_q;
	reg [WARN_W-1:0] wrise_q;
	reg [WARN_W-1:0] wfall_q;
	reg [7:0] esr_q;
	reg [7:0] ese_q;
	reg [WARN_W-1:0] wev_snap_q;
	reg [7:0] esr_snap_q;
	reg opc_wait_q;
	reg pon_cfg_q;
	reg pon_done_q;
	reg [2:0] seq_state_q;
	reg load_q;
	reg [3:0] load_slot_q;
	reg [12:0] load_cnt_q;
	reg hi_byte_pend_q;
	reg [7:0] hi_byte_q;
	reg err_push_q;
	reg [15:0] err_code_q;
	reg [15:0] errq_mem [0:ERRQ_DEPTH-1];
	reg [4:0] err_rp_q;
	reg [4:0] err_wp_q;
	reg [4:0] err_cnt_q;

	// ****************************************
	// warning transitions
	// ****************************************
	// rising and falling edge set
	wire [WARN_W-1:0] wset = (wcond & ~wprev_q & wrise_q) | (~wcond & wprev_q & wfall_q);
	wire war_sum = |(wevent_q & wenable_q);
	wire event_summary_bit = |(esr_q & ese_q);
	wire [7:0] stb = {op_sum, 1'b0, event_summary_bit, 2'b00, 1'b0, war_sum, 1'b0};

	// ****************************************
	// command decode
	// ****************************************
	wire [3:0] op = pwdata[3:0];
	wire [7:0] arg = pwdata[15:8];
	wire cmd_wr = wr & (paddr == `ISCU_A_CMD);
	wire cls = cmd_wr & (op == `ISCU_OP_CLS);
	wire [WARN_W-1:0] wmax = `ISCU_WARN_MAX;
	wire wval_ok = (pwdata[31:WARN_W] == {(32-WARN_W){1'b0}}) && (pwdata[WARN_W-1:0] <= wmax);
	wire [12:0] gain_max = hi_range ? `ISCU_GAIN_HI_MAX : `ISCU_GAIN_LO_MAX;
	wire gain_ok = (pwdata[31:13] == 19'h00000) && (pwdata[12:0] <= gain_max);
	wire [15:0] word_in = {hi_byte_q, pwdata[7:0]};

	reg e_push;
	reg [15:0] e_code;
	always @* begin
		e_push = 1'b0;
		e_code = `ISCU_ERR_EXEC;
		if (wr) begin
			case (paddr)
			`ISCU_A_WENABLE, `ISCU_A_WRISE, `ISCU_A_WFALL: begin
				e_push = ~wval_ok;
			end
			`ISCU_A_ESE: begin
				e_push = pwdata > {16'h0000, `ISCU_BYTE_MAX};
			end
			`ISCU_A_GAIN: begin
				e_push = ~gain_ok;
			end
			`ISCU_A_WAVE: begin
				e_push = ~load_q;
			end
			`ISCU_A_CMD: begin
				case (op)
				`ISCU_OP_RCL: begin
					if (!in_range(arg, 8'h01, `ISCU_MEM_MAX)) begin
						e_push = 1'b1;
					end else if (output_on_q) begin
						e_push = 1'b1;
						e_code = `ISCU_ERR_OUT_ON;
					end
				end
				`ISCU_OP_RST: begin
					e_push = output_on_q;
					e_code = `ISCU_ERR_OUT_ON;
				end
				`ISCU_OP_SAV: begin
					e_push = ~in_range(arg, 8'h01, `ISCU_MEM_MAX);
				end
				`ISCU_OP_WREL: begin
					e_push = (arg != 8'h01) | ~warn_active | ~warn_clearable;
				end
				`ISCU_OP_SEQ: begin
					if (arg > `ISCU_SEQ_MAX) begin
						e_push = 1'b1;
					end else if (ext_mode) begin
						e_push = 1'b1;
						e_code = `ISCU_ERR_MODE;
					end else if (!output_on_q) begin
						e_push = 1'b1;
						e_code = `ISCU_ERR_OUT_OFF;
					end
				end
				`ISCU_OP_WDEL: begin
					if (!in_range(arg, 8'h01, `ISCU_SLOT_MAX)) begin
						e_push = 1'b1;
					end else if (output_on_q) begin
						e_push = 1'b1;
						e_code = `ISCU_ERR_OUT_ON;
					end
				end
				`ISCU_OP_OUTP, `ISCU_OP_PON, `ISCU_OP_TUNIT: begin
					e_push = arg > 8'h01;
				end
				`ISCU_OP_WLOAD: begin
					e_push = ~link_usb | ~in_range(arg, 8'h01, `ISCU_SLOT_MAX);
				end
				`ISCU_OP_CLS, `ISCU_OP_OPC: begin
					e_push = 1'b0;
				end
				default: begin
					e_push = 1'b1;
				end
				endcase
				// a new command cuts an upload short
				if (load_q)
					e_push = 1'b1;
			end
			default: begin
				e_push = 1'b0;
			end
			endcase
		end
	end
	wire cmd_ok = cmd_wr & ~e_push;

	// ****************************************
	// read data, captured in setup
	// ****************************************
	reg [31:0] rmux;
	always @* begin
		case (paddr)
		`ISCU_A_WCOND: rmux = {{(32-WARN_W){1'b0}}, wcond};
		`ISCU_A_WEVENT: rmux = {{(32-WARN_W){1'b0}}, wevent_q};
		`ISCU_A_WENABLE: rmux = {{(32-WARN_W){1'b0}}, wenable_q};
		`ISCU_A_WRISE: rmux = {{(32-WARN_W){1'b0}}, wrise_q};
		`ISCU_A_WFALL: rmux = {{(32-WARN_W){1'b0}}, wfall_q};
		`ISCU_A_ESR: rmux = {24'h000000, esr_q};
		`ISCU_A_ESE: rmux = {24'h000000, ese_q};
		`ISCU_A_STB: rmux = {24'h000000, stb};
		`ISCU_A_ERROR: rmux = (err_cnt_q == 5'h00) ? 32'h00000000 :
			{{16{errq_mem[err_rp_q][15]}}, errq_mem[err_rp_q]};
		`ISCU_A_GAIN: rmux = {19'h00000, gain_q};
		`ISCU_A_STATUS: rmux = {20'h00000, err_cnt_q, seq_state_q, load_q, pon_cfg_q,
			step_unit_ms_q, output_on_q};
		// query answers 1 once idle, flag untouched
		`ISCU_A_OPCQ: rmux = {31'h00000000, ~ops_busy & ~opc_wait_q};
		default: rmux = 32'h00000000;
		endcase
	end

	// ****************************************
	// error queue
	// ****************************************
	wire err_pop = rd & (paddr == `ISCU_A_ERROR) & (err_cnt_q != 5'h00);
	wire [4:0] last_wp = (err_wp_q == 5'h00) ? ERRQ_DEPTH[4:0] - 5'h01 : err_wp_q - 5'h01;
	wire q_full = (err_cnt_q == `ISCU_ERRQ_DEPTH) & ~err_pop;
	always @(posedge clk) begin
		if (err_push_q && !cls) begin
			// overflow marker in the last place
			if (q_full)
				errq_mem[last_wp] <= `ISCU_ERR_OVERFLOW;
			else
				errq_mem[err_wp_q] <= err_code_q;
		end
	end
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			err_rp_q <= 5'h00;
			err_wp_q <= 5'h00;
			err_cnt_q <= 5'h00;
			err_push_q <= 1'b0;
			err_code_q <= 16'h0000;
		end else begin
			err_push_q <= e_push;
			err_code_q <= e_code;
			if (cls) begin
				err_rp_q <= 5'h00;
				err_wp_q <= 5'h00;
				err_cnt_q <= 5'h00;
			end else begin
				if (err_pop)
					err_rp_q <= (err_rp_q == ERRQ_DEPTH[4:0] - 5'h01) ? 5'h00 : err_rp_q + 5'h01;
				if (err_push_q && !q_full)
					err_wp_q <= (err_wp_q == ERRQ_DEPTH[4:0] - 5'h01) ? 5'h00 : err_wp_q + 5'h01;
				err_cnt_q <= err_cnt_q + {4'h0, err_push_q & ~q_full} - {4'h0, err_pop};
			end
		end
	end

	// ****************************************
	// status registers and controls
	// ****************************************
	wire rd_wev = rd & (paddr == `ISCU_A_WEVENT);
	wire rd_esr = rd & (paddr == `ISCU_A_ESR);
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
			wprev_q <= {WARN_W{1'b0}};
			wevent_q <= {WARN_W{1'b0}};
			wenable_q <= {WARN_W{1'b0}};
			wrise_q <= {WARN_W{1'b0}};
			wfall_q <= {WARN_W{1'b0}};
			wev_snap_q <= {WARN_W{1'b0}};
			esr_snap_q <= 8'h00;
			esr_q <= `ISCU_ESR_RESET;
			ese_q <= 8'h00;
			opc_wait_q <= 1'b0;
			output_on_q <= 1'b0;
			pon_cfg_q <= PON_DEFAULT;
			pon_done_q <= 1'b0;
			step_unit_ms_q <= 1'b0;
			gain_q <= 13'h0000;
			seq_state_q <= 3'h0;
			seq_go_q <= 1'b0;
			seq_action_q <= 3'h0;
			slot_clear_q <= 1'b0;
			slot_q <= 4'h0;
			slot_shape_q <= `ISCU_SHAPE_SINE;
			recall_q <= 1'b0;
			save_q <= 1'b0;
			mem_q <= 5'h00;
			factory_reset_q <= 1'b0;
			warn_release_q <= 1'b0;
			load_q <= 1'b0;
			load_slot_q <= 4'h0;
			load_cnt_q <= 13'h0000;
			hi_byte_pend_q <= 1'b0;
			hi_byte_q <= 8'h00;
			wave_we_q <= 1'b0;
			wave_addr_q <= 12'h000;
			wave_data_q <= 16'h0000;
		end else begin
			seq_go_q <= 1'b0;
			slot_clear_q <= 1'b0;
			recall_q <= 1'b0;
			save_q <= 1'b0;
			factory_reset_q <= 1'b0;
			warn_release_q <= 1'b0;
			wave_we_q <= 1'b0;
			wprev_q <= wcond;
			if (setup) begin
				prdata <= rmux;
				wev_snap_q <= wevent_q;
				esr_snap_q <= esr_q;
			end
			// latched; only the bits that were read are cleared, new sets win
			if (cls)
				wevent_q <= wset;
			else if (rd_wev)
				wevent_q <= (wevent_q & ~wev_snap_q) | wset;
			else
				wevent_q <= wevent_q | wset;
			if (cls)
				esr_q <= {3'b000, e_push, 3'b000, 1'b0};
			else if (rd_esr)
				esr_q <= (esr_q & ~esr_snap_q) | {3'b000, err_push_q, 3'b000,
					opc_wait_q & ~ops_busy};
			else
				esr_q <= esr_q | {3'b000, err_push_q, 3'b000, opc_wait_q & ~ops_busy};
			if (cmd_ok && op == `ISCU_OP_OPC)
				opc_wait_q <= 1'b1;
			else if (!ops_busy)
				opc_wait_q <= 1'b0;
			if (wr && wval_ok && paddr == `ISCU_A_WENABLE)
				wenable_q <= pwdata[WARN_W-1:0];
			if (wr && wval_ok && paddr == `ISCU_A_WRISE)
				wrise_q <= pwdata[WARN_W-1:0];
			if (wr && wval_ok && paddr == `ISCU_A_WFALL)
				wfall_q <= pwdata[WARN_W-1:0];
			if (wr && !e_push && paddr == `ISCU_A_ESE)
				ese_q <= pwdata[7:0];
			if (wr && gain_ok && paddr == `ISCU_A_GAIN)
				gain_q <= pwdata[12:0];
			// power-on output unless restarted after a lock
			if (startup_done && !pon_done_q) begin
				pon_done_q <= 1'b1;
				if (pon_cfg_q && !fault_restart)
					output_on_q <= 1'b1;
			end
			if (cmd_ok) begin
				case (op)
				`ISCU_OP_OUTP: output_on_q <= arg[0];
				`ISCU_OP_PON: pon_cfg_q <= arg[0];
				`ISCU_OP_TUNIT: step_unit_ms_q <= arg[0];
				`ISCU_OP_SEQ: begin
					seq_go_q <= 1'b1;
					seq_action_q <= arg[2:0];
					seq_state_q <= arg[2:0];
				end
				`ISCU_OP_WDEL: begin
					slot_clear_q <= 1'b1;
					slot_q <= arg[3:0] - 4'h1;
					if (arg >= `ISCU_SLOT_TRI)
						slot_shape_q <= `ISCU_SHAPE_TRIANGLE;
					else if (arg >= `ISCU_SLOT_SQU)
						slot_shape_q <= `ISCU_SHAPE_SQUARE;
					else
						slot_shape_q <= `ISCU_SHAPE_SINE;
				end
				`ISCU_OP_RCL: begin
					recall_q <= 1'b1;
					mem_q <= arg[4:0];
				end
				`ISCU_OP_SAV: begin
					save_q <= 1'b1;
					mem_q <= arg[4:0];
				end
				`ISCU_OP_RST: begin
					factory_reset_q <= 1'b1;
					gain_q <= 13'h0000;
					step_unit_ms_q <= 1'b0;
				end
				`ISCU_OP_WREL: warn_release_q <= 1'b1;
				`ISCU_OP_WLOAD: begin
					load_q <= 1'b1;
					load_slot_q <= arg[3:0] - 4'h1;
					load_cnt_q <= 13'h0000;
					hi_byte_pend_q <= 1'b0;
				end
				default: begin
					load_q <= load_q;
				end
				endcase
			end else if (cmd_wr && load_q) begin
				load_q <= 1'b0;
			end
			// bytes pair high first into 4096 words
			if (wr && load_q && paddr == `ISCU_A_WAVE) begin
				hi_byte_pend_q <= ~hi_byte_pend_q;
				if (!hi_byte_pend_q) begin
					hi_byte_q <= pwdata[7:0];
				end else begin
					wave_we_q <= 1'b1;
					wave_addr_q <= load_cnt_q[11:0];
					wave_data_q <= clamp_sample(word_in);
					load_cnt_q <= load_cnt_q + 13'h0001;
					if (load_cnt_q == `ISCU_WAVE_WORDS - 13'h0001)
						load_q <= 1'b0;
				end
			end
		end
	end

endmodule

// ---- iscu_defines.vh ----
// constants for the instrument status and command unit
// assumes a 32-bit apb master and byte addresses in an 8-bit window
`ifndef ISCU_DEFINES_VH
`define ISCU_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define ISCU_A_WCOND 8'h00
`define ISCU_A_WEVENT 8'h04
`define ISCU_A_WENABLE 8'h08
`define ISCU_A_WRISE 8'h0C
`define ISCU_A_WFALL 8'h10
`define ISCU_A_ESR 8'h14
`define ISCU_A_ESE 8'h18
`define ISCU_A_STB 8'h1C
`define ISCU_A_ERROR 8'h20
`define ISCU_A_CMD 8'h24
`define ISCU_A_GAIN 8'h28
`define ISCU_A_WAVE 8'h2C
`define ISCU_A_STATUS 8'h30
`define ISCU_A_OPCQ 8'h34

// ****************************************
// limits and codes
// ****************************************
`define ISCU_WARN_MAX 15'h74FB
`define ISCU_BYTE_MAX 16'h00FF
`define ISCU_GAIN_LO_MAX 13'h0898
`define ISCU_GAIN_HI_MAX 13'h1130
`define ISCU_SAMP_MIN 16'hC000
`define ISCU_SAMP_MAX 16'h3FFF
`define ISCU_WAVE_WORDS 13'h1000
`define ISCU_MEM_MAX 8'h1E
`define ISCU_SLOT_MAX 8'h10
`define ISCU_SLOT_SQU 8'h09
`define ISCU_SLOT_TRI 8'h0D
`define ISCU_SEQ_MAX 8'h04
`define ISCU_ERRQ_DEPTH 5'h14
`define ISCU_ERR_OUT_ON 16'h0001
`define ISCU_ERR_OUT_OFF 16'h0002
`define ISCU_ERR_MODE 16'h0003
`define ISCU_ERR_EXEC 16'hFF38
`define ISCU_ERR_OVERFLOW 16'hFEA2

// ****************************************
// command opcodes, cmd[3:0], argument cmd[15:8]
// ****************************************
`define ISCU_OP_CLS 4'h1
`define ISCU_OP_OPC 4'h2
`define ISCU_OP_RCL 4'h3
`define ISCU_OP_RST 4'h4
`define ISCU_OP_SAV 4'h5
`define ISCU_OP_WREL 4'h6
`define ISCU_OP_SEQ 4'h7
`define ISCU_OP_WDEL 4'h8
`define ISCU_OP_OUTP 4'h9
`define ISCU_OP_PON 4'hA
`define ISCU_OP_TUNIT 4'hB
`define ISCU_OP_WLOAD 4'hC

// ****************************************
// bit positions
// ****************************************
`define ISCU_ESR_OPC 0
`define ISCU_ESR_EXE 4
`define ISCU_ESR_RESET 8'h80
`define ISCU_STB_WAR 1
`define ISCU_STB_ESB 5
`define ISCU_STB_OPR 7
`define ISCU_SHAPE_SINE 2'h0
`define ISCU_SHAPE_SQUARE 2'h1
`define ISCU_SHAPE_TRIANGLE 2'h2

`endif

// ---- iscu_monitor.sv ----
// port checker for the status and command unit
// assumes a bind onto iscu_top; single clock domain
`timescale 1ns/1ps
module iscu_monitor (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// device controls
	input wire output_on_q,
	input wire [12:0] gain_q,
	input wire seq_go_q,
	input wire [2:0] seq_action_q,
	input wire slot_clear_q,
	input wire [3:0] slot_q,
	input wire [1:0] slot_shape_q,
	input wire recall_q,
	input wire save_q,
	input wire [4:0] mem_q,
	input wire factory_reset_q,
	input wire warn_release_q,
	// sample write
	input wire wave_we_q,
	input wire [15:0] wave_data_q
);
	// ****
	// properties
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_slot_off;
		slot_clear_q |-> !$past(output_on_q);
	endproperty
	a_slot_off: assert property (p_slot_off) else $error("slot clear with output on");
	property p_slot_shape;
		slot_clear_q |-> slot_shape_q == (slot_q < 4'h8 ? 2'h0 : slot_q < 4'hC ? 2'h1 : 2'h2);
	endproperty
	a_slot_shape: assert property (p_slot_shape) else $error("wrong default shape");
	property p_rcl_off;
		recall_q || factory_reset_q |-> !$past(output_on_q);
	endproperty
	a_rcl_off: assert property (p_rcl_off) else $error("recall or reset with output on");
	property p_mem;
		recall_q || save_q |-> mem_q >= 5'h01 && mem_q <= 5'h1E;
	endproperty
	a_mem: assert property (p_mem) else $error("memory number out of range");
	property p_seq_act;
		seq_go_q |-> seq_action_q <= 3'h4 ##1 !seq_go_q;
	endproperty
	a_seq_act: assert property (p_seq_act) else $error("bad sequence action");
	property p_seq_on;
		seq_go_q |-> $past(output_on_q);
	endproperty
	a_seq_on: assert property (p_seq_on) else $error("sequence with output off");
	property p_clamp;
		wave_we_q |-> $signed(wave_data_q) >= $signed(16'hC000) && $signed(wave_data_q) <= 16'sh3FFF;
	endproperty
	a_clamp: assert property (p_clamp) else $error("sample not clamped");
	property p_gain;
		gain_q <= 13'h1130;
	endproperty
	a_gain: assert property (p_gain) else $error("gain above limit");
	property p_rel;
		warn_release_q |=> !warn_release_q;
	endproperty
	a_rel: assert property (p_rel) else $error("release pulse too long");
endmodule

// ---- iscu_plant.sv ----
// model of the instrument around the unit: start-up and busy
// assumes command pulses from iscu_top on the same clock
`timescale 1ns/1ps
module iscu_plant (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// command pulses
	input wire seq_go_q,
	input wire recall_q,
	input wire factory_reset_q,
	// status back to the unit
	output wire startup_done_pin,
	output wire ops_busy_pin
);
	reg [3:0] boot_q;
	reg [2:0] busy_q;
	assign startup_done_pin = boot_q == 4'hF;
	assign ops_busy_pin = busy_q != 3'h0;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_q <= 4'h0;
			busy_q <= 3'h0;
		end else begin
			if (boot_q != 4'hF)
				boot_q <= boot_q + 4'h1;
			if (seq_go_q || recall_q || factory_reset_q)
				busy_q <= 3'h6;
			else if (busy_q != 3'h0)
				busy_q <= busy_q - 3'h1;
		end
	end
endmodule

// ---- testbench.sv ----
// self-checking bench for the status and command unit
// assumes apb answers without wait states but waits are bounded
`timescale 1ns/1ps
`include "iscu_defines.vh"
module testbench;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, r;
	logic [14:0] warn = 15'h0;
	logic ext = 0, add_m = 0, syn_m = 0, hi = 0, usb = 0, flt = 0, wact = 0, wclr = 0;
	logic [4:0] last_mem;
	logic serr;
	wire pready, pslverr, startup, busy, on, ms, go, clr, rcl, sav, frst, rel, we;
	wire [31:0] prdata;
	wire [12:0] gain;
	wire [2:0] act;
	wire [3:0] slot;
	wire [1:0] shape;
	wire [4:0] mem;
	wire [11:0] wa;
	wire [15:0] wd;
	logic [15:0] wave [0:4095];
	logic [15:0] w;
	logic [2:0] last_act;
	int n_mismatch = 0, n_compared = 0, n_we = 0, n_rel = 0, i;
	int slots [6] = '{1, 8, 9, 12, 13, 16};
	always #20 clk = ~clk;
	iscu_top #(.PON_DEFAULT(1'b1)) iscu_top_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .warn_cond_pin(warn), .op_summary_pin(1'b0),
		.external_input_mode(ext), .added_input_mode(add_m), .external_sync_mode(syn_m),
		.high_range_pin(hi), .link_usb_pin(usb), .startup_done_pin(startup),
		.fault_restart_pin(flt), .warn_active_pin(wact), .warn_clearable_pin(wclr),
		.ops_busy_pin(busy), .output_on_q(on), .step_unit_ms_q(ms), .gain_q(gain),
		.seq_go_q(go), .seq_action_q(act), .slot_clear_q(clr), .slot_q(slot),
		.slot_shape_q(shape), .recall_q(rcl), .save_q(sav), .mem_q(mem),
		.factory_reset_q(frst), .warn_release_q(rel), .wave_we_q(we), .wave_addr_q(wa),
		.wave_data_q(wd));
	iscu_plant iscu_plant_inst (.clk(clk), .rst_n(rst_n), .seq_go_q(go), .recall_q(rcl),
		.factory_reset_q(frst), .startup_done_pin(startup), .ops_busy_pin(busy));
	always @(posedge clk) begin
		if (we) begin
			wave[wa] <= wd;
			n_we <= n_we + 1;
		end
		if (go)
			last_act <= act;
		if (rcl || sav)
			last_mem <= mem;
		if (rel)
			n_rel <= n_rel + 1;
	end
	// ****
	// bus tasks
	// ****
	task results;
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			n_mismatch++;
		end
	endtask
	task xfer(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		r = prdata;
		serr = pslverr;
		psel <= 0;
		penable <= 0;
		if (k >= 50) begin
			n_mismatch++;
			results();
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		xfer(0, a, 32'h0);
		chk(r, e);
	endtask
	task cmd(input logic [3:0] op, input logic [7:0] arg);
		wr(`ISCU_A_CMD, {16'h0000, arg, 4'h0, op});
	endtask
	task err(input logic [15:0] c);
		rd(`ISCU_A_ERROR, {{16{c[15]}}, c});
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// ****
	// scenarios
	// ****
	initial begin
		tick(16);
		rst_n <= 1;
		tick(24);
		chk(on, 1);
		rd(`ISCU_A_ESR, 32'h80);
		rd(`ISCU_A_ESR, 0);
		chk(serr, 0);
		xfer(0, 8'h3C, 0);
		chk(serr, 1);
		chk(r, 0);
		cmd(`ISCU_OP_WDEL, 1);
		cmd(`ISCU_OP_RCL, 1);
		cmd(`ISCU_OP_RST, 0);
		for (i = 0; i < 3; i++) err(`ISCU_ERR_OUT_ON);
		for (i = 0; i < 5; i++) begin
			cmd(`ISCU_OP_SEQ, i[7:0]);
			tick(2);
			chk(last_act, i);
		end
		cmd(`ISCU_OP_SEQ, 5);
		err(`ISCU_ERR_EXEC);
		for (i = 0; i < 3; i++) begin
			{ext, add_m, syn_m} <= 3'b100 >> i;
			tick(4);
			cmd(`ISCU_OP_SEQ, 1);
			err(`ISCU_ERR_MODE);
		end
		{ext, add_m, syn_m} <= 3'b000;
		cmd(`ISCU_OP_OUTP, 0);
		cmd(`ISCU_OP_SEQ, 1);
		err(`ISCU_ERR_OUT_OFF);
		// default shape follows the slot group
		foreach (slots[i]) begin
			cmd(`ISCU_OP_WDEL, slots[i][7:0]);
			tick(2);
			chk({slot, shape}, {slots[i][3:0] - 4'h1,
				slots[i] > 12 ? 2'h2 : slots[i] > 8 ? 2'h1 : 2'h0});
		end
		cmd(`ISCU_OP_SAV, 31);
		cmd(`ISCU_OP_RCL, 0);
		cmd(`ISCU_OP_RCL, 30);
		err(`ISCU_ERR_EXEC);
		err(`ISCU_ERR_EXEC);
		err(0);
		chk(last_mem, 30);
		cmd(`ISCU_OP_SAV, 1);
		tick(2);
		chk(last_mem, 1);
		cmd(`ISCU_OP_TUNIT, 1);
		tick(1);
		chk(ms, 1);
		cmd(`ISCU_OP_TUNIT, 0);
		tick(1);
		chk(ms, 0);
		wr(`ISCU_A_WENABLE, 32'h74FB);
		wr(`ISCU_A_WENABLE, 32'h74FC);
		rd(`ISCU_A_WENABLE, 32'h74FB);
		err(`ISCU_ERR_EXEC);
		wr(`ISCU_A_WRISE, 1);
		wr(`ISCU_A_WFALL, 2);
		warn <= 15'h7;
		tick(5);
		rd(`ISCU_A_WCOND, 7);
		rd(`ISCU_A_WEVENT, 1);
		warn <= 15'h0;
		tick(5);
		rd(`ISCU_A_STB, 32'h02);
		rd(`ISCU_A_WEVENT, 2);
		rd(`ISCU_A_WEVENT, 0);
		xfer(0, `ISCU_A_ESR, 0);
		wr(`ISCU_A_ESE, 1);
		cmd(`ISCU_OP_OPC, 0);
		tick(10);
		rd(`ISCU_A_STB, 32'h20);
		rd(`ISCU_A_OPCQ, 1);
		rd(`ISCU_A_ESR, 1);
		rd(`ISCU_A_STB, 0);
		wr(`ISCU_A_GAIN, 2200);
		wr(`ISCU_A_GAIN, 2201);
		rd(`ISCU_A_GAIN, 2200);
		hi <= 1;
		tick(4);
		wr(`ISCU_A_GAIN, 4400);
		wr(`ISCU_A_GAIN, 4401);
		rd(`ISCU_A_GAIN, 4400);
		cmd(`ISCU_OP_RST, 0);
		rd(`ISCU_A_GAIN, 0);
		cmd(`ISCU_OP_WREL, 1);
		wact <= 1;
		tick(4);
		cmd(`ISCU_OP_WREL, 1);
		for (i = 0; i < 4; i++) err(`ISCU_ERR_EXEC);
		wclr <= 1;
		tick(4);
		cmd(`ISCU_OP_WREL, 1);
		tick(2);
		chk(n_rel, 1);
		for (i = 0; i < 22; i++) cmd(4'hF, 0);
		for (i = 0; i < 19; i++) err(`ISCU_ERR_EXEC);
		err(`ISCU_ERR_OVERFLOW);
		err(0);
		cmd(4'hF, 0);
		cmd(`ISCU_OP_CLS, 0);
		err(0);
		rd(`ISCU_A_ESR, 0);
		cmd(`ISCU_OP_WLOAD, 1);
		err(`ISCU_ERR_EXEC);
		usb <= 1;
		tick(4);
		cmd(`ISCU_OP_WLOAD, 2);
		for (i = 0; i < 4096; i++) begin
			w = i == 0 ? 16'h7FFF : i == 1 ? 16'h8000 : i == 2 ? 16'hC123 : i[15:0];
			wr(`ISCU_A_WAVE, w[15:8]);
			wr(`ISCU_A_WAVE, w[7:0]);
		end
		tick(2);
		chk(n_we, 4096);
		chk(wave[0], 16'h3FFF);
		chk(wave[1], 16'hC000);
		chk(wave[2], 16'hC123);
		chk(wave[4095], 16'h0FFF);
		rd(`ISCU_A_STATUS, 32'h44);
		cmd(`ISCU_OP_PON, 0);
		rd(`ISCU_A_STATUS, 32'h40);
		flt <= 1;
		rst_n <= 0;
		tick(4);
		rst_n <= 1;
		tick(24);
		chk(on, 0);
		results();
	end
endmodule
bind iscu_top iscu_monitor iscu_monitor_inst (.clk, .rst_n, .output_on_q, .gain_q, .seq_go_q,
	.seq_action_q, .slot_clear_q, .slot_q, .slot_shape_q, .recall_q, .save_q, .mem_q,
	.factory_reset_q, .warn_release_q, .wave_we_q, .wave_data_q);
